//--- hdl/orc_top.sv
`timescale 1ns/1ns
module orc_top import orc_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic word_valid_i,
	input wire logic [15:0] spi_word_i,
	input wire logic [1:0] load_profile_pin_i,
	input wire logic [1:0] ext_clk_i,
	input wire logic [1:0] int_clk_tick_i,
	input wire logic [1:0] turn_on_i,
	input wire logic [1:0] window_active_i,
	input wire logic [1:0] retry_attempt_i,
	input wire logic [1:0] retry_counter_reset_i,
	output logic [17:0] ocr_readback_o,
	output logic [17:0] retry_readback_o,
	output orc_prot_t [1:0] prot_o,
	output orc_ctl_t [1:0] ctl_o,
	output logic [1:0] motor_profile_o,
	output logic [1:0] pwm_tick_o,
	output logic [1:0] sense_enable_o,
	output logic [1:0] retry_allowed_o,
	output logic [1:0] retry_full_o
);
	logic [8:0] ocr_reg [2];
	logic [8:0] ocr_next [2];
	logic [8:0] retry_reg [2];
	logic [8:0] retry_next [2];
	logic [1:0] ext_s1_reg, ext_s2_reg, ext_s3_reg;
	logic [1:0] ext_s1_next, ext_s2_next, ext_s3_next;
	logic [9:0] div_cnt_reg [2];
	logic [9:0] div_cnt_next [2];
	logic [4:0] retry_cnt_reg [2];
	logic [4:0] retry_cnt_next [2];
	logic [1:0] pwm_tick_reg, pwm_tick_next;
	logic [1:0] sense_en_reg, sense_en_next;
	logic [1:0] allowed_reg, allowed_next;
	logic [1:0] full_reg, full_next;
	logic [1:0] motor_reg;
	orc_prot_t [1:0] prot_reg;
	orc_ctl_t [1:0] ctl_reg;
	orc_prot_t [1:0] prot_w;
	orc_ctl_t [1:0] ctl_w;
	logic [1:0] motor_w;
	logic [2:0] word_addr;
	logic word_bank;
	assign word_addr = spi_word_i[ADDR_HI:ADDR_LO];
	assign word_bank = spi_word_i[BANK_BIT];

	// External clock passes three flops, edge counts when second is high and third still low
	always_comb begin
		ext_s1_next = ext_clk_i;
		ext_s2_next = ext_s1_reg;
		ext_s3_next = ext_s2_reg;
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ext_s1_reg <= 2'h0;
			ext_s2_reg <= 2'h0;
			ext_s3_reg <= 2'h0;
		end else begin
			ext_s1_reg <= ext_s1_next;
			ext_s2_reg <= ext_s2_next;
			ext_s3_reg <= ext_s3_next;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic ext_rise;
			logic [9:0] div_max;
			assign ext_rise = ext_s2_reg[ch] && !ext_s3_reg[ch];

			orc_decode u_dec (
				.ocr_i(ocr_reg[ch]),
				.retry_i(retry_reg[ch]),
				.load_profile_pin_i(load_profile_pin_i[ch]),
				.prot_o(prot_w[ch]),
				.ctl_o(ctl_w[ch]),
				.motor_o(motor_w[ch])
			);

			// Config write only on a complete word for this bank
			always_comb begin
				ocr_next[ch] = ocr_reg[ch];
				retry_next[ch] = retry_reg[ch];
				if (word_valid_i && (word_bank == 1'(ch))) begin
					if (word_addr == ADDR_OCR) begin
						ocr_next[ch] = spi_word_i[DATA_W-1:0];
					end else if (word_addr == ADDR_RETRY) begin
						retry_next[ch] = spi_word_i[DATA_W-1:0];
					end
				end
			end

			// Divider: 512 or 256 external edges, or internal tick passed through
			assign div_max = ctl_w[ch].ext_clock_divider_sel ? DIV_SLOW : DIV_FAST;
			always_comb begin
				div_cnt_next[ch] = div_cnt_reg[ch];
				pwm_tick_next[ch] = 1'b0;
				if (ctl_w[ch].clock_int_sel) begin
					pwm_tick_next[ch] = int_clk_tick_i[ch];
					div_cnt_next[ch] = 10'h000;
				end else if (ext_rise) begin
					if (div_cnt_reg[ch] >= div_max - 10'h001) begin
						div_cnt_next[ch] = 10'h000;
						pwm_tick_next[ch] = 1'b1;
					end else begin
						div_cnt_next[ch] = div_cnt_reg[ch] + 10'h001;
					end
				end
			end

			// Sense is blanked while any protection window is active
			always_comb begin
				sense_en_next[ch] = !window_active_i[ch] && !turn_on_i[ch];
			end

			// Retry counter: only explicit reset clears it, never delatch or fault removal
			always_comb begin
				retry_cnt_next[ch] = retry_cnt_reg[ch];
				if (retry_counter_reset_i[ch]) begin
					// An attempt in the clearing cycle is not lost
					retry_cnt_next[ch] = retry_attempt_i[ch] ? 5'h01 : 5'h00;
				end else if (retry_attempt_i[ch] && retry_cnt_reg[ch] != RETRY_LIMIT) begin
					retry_cnt_next[ch] = retry_cnt_reg[ch] + 5'h01;
				end
				full_next[ch] = (retry_cnt_next[ch] == RETRY_LIMIT);
				allowed_next[ch] = ctl_w[ch].retry_en &&
					(ctl_w[ch].unlimited || retry_cnt_next[ch] != RETRY_LIMIT);
			end

			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					ocr_reg[ch] <= CFG_RESET;
					retry_reg[ch] <= CFG_RESET;
					div_cnt_reg[ch] <= 10'h000;
					retry_cnt_reg[ch] <= 5'h00;
				end else begin
					ocr_reg[ch] <= ocr_next[ch];
					retry_reg[ch] <= retry_next[ch];
					div_cnt_reg[ch] <= div_cnt_next[ch];
					retry_cnt_reg[ch] <= retry_cnt_next[ch];
				end
			end
		end
	endgenerate

	// Output flops; decoded settings lag the register by one cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pwm_tick_reg <= 2'h0;
			sense_en_reg <= 2'h0;
			allowed_reg <= 2'h0;
			full_reg <= 2'h0;
			motor_reg <= 2'h0;
			prot_reg <= '0;
			ctl_reg <= '0;
		end else begin
			pwm_tick_reg <= pwm_tick_next;
			sense_en_reg <= sense_en_next;
			allowed_reg <= allowed_next;
			full_reg <= full_next;
			motor_reg <= motor_w;
			prot_reg <= prot_w;
			ctl_reg <= ctl_w;
		end
	end

	assign ocr_readback_o = {ocr_reg[1], ocr_reg[0]};
	assign retry_readback_o = {retry_reg[1], retry_reg[0]};
	assign prot_o = prot_reg;
	assign ctl_o = ctl_reg;
	assign motor_profile_o = motor_reg;
	assign pwm_tick_o = pwm_tick_reg;
	assign sense_enable_o = sense_en_reg;
	assign retry_allowed_o = allowed_reg;
	assign retry_full_o = full_reg;

	// Checks
	bank_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		word_valid_i && !spi_word_i[BANK_BIT] && word_addr == ADDR_OCR
		|=> ocr_reg[0] == $past(spi_word_i[DATA_W-1:0]) && $stable(ocr_reg[1]))
		else $error("bank write wrong");
	sense_blank_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		window_active_i[0] |=> !sense_enable_o[0]) else $error("sense during window");
	retry_cap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		retry_full_o[0] && !ctl_reg[0].unlimited && !retry_counter_reset_i[0] && $stable(retry_reg[0])
		|=> !retry_allowed_o[0]) else $error("retry past limit");
	count_keep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!retry_counter_reset_i[0] && !retry_attempt_i[0] |=> $stable(retry_cnt_reg[0]))
		else $error("counter lost");
	profile_inv_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		motor_profile_o[0] == $past(load_profile_pin_i[0] ^ retry_reg[0][B_INV]))
		else $error("profile wrong");
	low_range_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(ocr_reg[0][B_RANGE]) |-> prot_o[0].low_level == orc_low1) else $error("low level wrong");
	retry_pol_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> ctl_o[0].retry_en == (motor_profile_o[0] ~^ $past(retry_reg[0][B_RETRY])))
		else $error("retry enable wrong");
	div_range_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		div_cnt_reg[0] < DIV_SLOW) else $error("divider overrun");

	// Decoded fields follow the registers one cycle later; reset edge skipped
	upper_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> prot_o[1].upper_threshold_sel == $past(ocr_reg[1][B_OCH]))
		else $error("upper select wrong");
	middle_motor_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		motor_profile_o[0] |-> !prot_o[0].middle_threshold_sel)
		else $error("middle select in motor");
	middle_light_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) && !motor_profile_o[0] |-> prot_o[0].middle_threshold_sel == $past(ocr_reg[0][B_OCM]))
		else $error("middle select wrong");
	mid_stage_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> prot_o[0].mid_stage_en == !motor_profile_o[0])
		else $error("middle stage wrong");
	light_win2_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) && !motor_profile_o[1] |-> prot_o[1].second_window_en)
		else $error("second window off in lighting");
	motor_win2_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		motor_profile_o[1] |-> !prot_o[1].second_window_en)
		else $error("second window on in motor");
	ratio_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> prot_o[0].sense_ratio_sel == $past(ocr_reg[0][B_RATIO]))
		else $error("sense ratio wrong");
	ratio_scale_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> prot_o[1].sense_ratio_sel == $past(ocr_reg[1][B_RATIO]))
		else $error("threshold scale wrong");
	low_mid_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$past(ocr_reg[0][B_RANGE]) && !$past(ocr_reg[0][B_OCL]) |-> prot_o[0].low_level == orc_low2)
		else $error("medium low level wrong");
	low_min_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$past(ocr_reg[1][B_RANGE]) && $past(ocr_reg[1][B_OCL]) |-> prot_o[1].low_level == orc_low3)
		else $error("lowest low level wrong");
	light_win1_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) && !motor_profile_o[0] |->
		prot_o[0].first_window == ($past(ocr_reg[0][B_TOCH]) ? orc_win_high2 : orc_win_high1))
		else $error("first window wrong");
	mid_window_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) && !motor_profile_o[0] |->
		prot_o[0].second_window == ($past(ocr_reg[0][B_TOCM]) ? orc_win_mid2_l : orc_win_mid1_l))
		else $error("second window wrong");
	motor_mid_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) && motor_profile_o[0] && !$past(ocr_reg[0][B_TOCH]) |->
		prot_o[0].first_window == ($past(ocr_reg[0][B_TOCM]) ? orc_win_mid2_m : orc_win_mid1_m))
		else $error("motor middle window wrong");
	motor_high_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) && motor_profile_o[0] && $past(ocr_reg[0][B_TOCH]) |->
		prot_o[0].first_window == ($past(ocr_reg[0][B_TOCM]) ? orc_win_high2 : orc_win_high1))
		else $error("motor high window wrong");
	clk_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> ctl_o[0].clock_int_sel == $past(ocr_reg[0][B_CLKINT]))
		else $error("clock select wrong");
	div_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> ctl_o[1].ext_clock_divider_sel == $past(ocr_reg[1][B_DIV]))
		else $error("divider select wrong");
	offset_pol_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> ctl_o[0].sense_offset_polarity == $past(retry_reg[0][B_OFP]))
		else $error("offset polarity wrong");
	period_sel_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> ctl_o[1].period == $past({retry_reg[1][B_PER_HI], retry_reg[1][B_PER_LO]}))
		else $error("retry period wrong");
	motor_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!$past(rst_i) |-> motor_profile_o[1] == $past(load_profile_pin_i[1] ^ retry_reg[1][B_INV]))
		else $error("profile wrong on bank one");

	// PWM clock source
	int_tick_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctl_w[0].clock_int_sel |=> pwm_tick_o[0] == $past(int_clk_tick_i[0]))
		else $error("internal tick lost");
	ext_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctl_w[1].clock_int_sel |=> div_cnt_reg[1] == 10'h000)
		else $error("divider runs on internal clock");

	// Retry limit and enable
	unlim_allow_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctl_reg[0].unlimited && ctl_reg[0].retry_en && $stable(retry_reg[0]) && $stable(load_profile_pin_i[0])
		|=> retry_allowed_o[0])
		else $error("unlimited retry blocked");
	retry_off_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!ctl_w[1].retry_en |=> !retry_allowed_o[1])
		else $error("retry while disabled");
	cnt_sat_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		retry_cnt_reg[0] <= RETRY_LIMIT)
		else $error("retry counter overrun");
	full_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		retry_full_o[1] == (retry_cnt_reg[1] == RETRY_LIMIT))
		else $error("full flag wrong");
	cnt_step_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		retry_attempt_i[1] && !retry_counter_reset_i[1] && retry_cnt_reg[1] != RETRY_LIMIT
		|=> retry_cnt_reg[1] == $past(retry_cnt_reg[1]) + 5'h01)
		else $error("attempt not counted");

	// Register writes and sense blanking
	bank_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		word_valid_i && spi_word_i[BANK_BIT] && word_addr == ADDR_RETRY
		|=> retry_reg[1] == $past(spi_word_i[DATA_W-1:0]) && $stable(retry_reg[0]))
		else $error("bank one write wrong");
	no_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!word_valid_i |=> $stable(ocr_reg[0]) && $stable(retry_reg[1]))
		else $error("write without strobe");
	sense_open_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!window_active_i[1] && !turn_on_i[1] |=> sense_enable_o[1])
		else $error("sense blanked outside window");
	cov_write: cover property (@(posedge ref_clk_i) word_valid_i && word_addr == ADDR_RETRY);
	cov_full: cover property (@(posedge ref_clk_i) retry_full_o[1]);
	cov_tick: cover property (@(posedge ref_clk_i) pwm_tick_o[0] && !ctl_o[0].clock_int_sel);
	cov_motor: cover property (@(posedge ref_clk_i) motor_profile_o[0] && prot_o[0].first_window == orc_win_high2);
	cov_unlim: cover property (@(posedge ref_clk_i) retry_allowed_o[0] && retry_full_o[0]);
endmodule

//--- hdl/orc_pkg.sv
package orc_pkg;
	// SPI word layout
	localparam int SPI_W = 16;
	localparam int BANK_BIT = 13;
	localparam int ADDR_HI = 12;
	localparam int ADDR_LO = 10;
	localparam int DATA_W = 9;
	localparam logic [2:0] ADDR_OCR = 3'h4;
	localparam logic [2:0] ADDR_RETRY = 3'h5;
	localparam logic [8:0] CFG_RESET = 9'h000;
	// Field positions, both registers
	localparam int B_RANGE = 8;
	localparam int B_DIV = 7;
	localparam int B_CLKINT = 6;
	localparam int B_RATIO = 5;
	localparam int B_TOCH = 4;
	localparam int B_TOCM = 3;
	localparam int B_OCH = 2;
	localparam int B_OCM = 1;
	localparam int B_OCL = 0;
	localparam int B_OFP = 8;
	localparam int B_INV = 4;
	localparam int B_PER_HI = 3;
	localparam int B_PER_LO = 2;
	localparam int B_UNLIM = 1;
	localparam int B_RETRY = 0;
	// Timing
	localparam logic [9:0] DIV_SLOW = 10'h200;
	localparam logic [9:0] DIV_FAST = 10'h100;
	localparam logic [4:0] RETRY_LIMIT = 5'h10;
	// Window duration codes
	typedef enum logic [2:0] {
		orc_win_high1, orc_win_high2, orc_win_mid1_l, orc_win_mid2_l,
		orc_win_mid1_m, orc_win_mid2_m
	} orc_win_t;
	// Threshold levels
	typedef enum logic [1:0] {orc_low1, orc_low2, orc_low3} orc_low_t;
	typedef struct packed {
		logic upper_threshold_sel;
		logic middle_threshold_sel;
		logic mid_stage_en;
		orc_low_t low_level;
		logic sense_ratio_sel;
		orc_win_t first_window;
		orc_win_t second_window;
		logic second_window_en;
	} orc_prot_t;
	typedef struct packed {
		logic retry_en;
		logic unlimited;
		logic [1:0] period;
		logic sense_offset_polarity;
		logic ext_clock_divider_sel;
		logic clock_int_sel;
	} orc_ctl_t;
endpackage

//--- hdl/orc_decode.sv
`timescale 1ns/1ns
// Turns one bank's two raw registers into protection and control settings
module orc_decode import orc_pkg::*; (
	input wire logic [8:0] ocr_i,
	input wire logic [8:0] retry_i,
	input wire logic load_profile_pin_i,
	output orc_prot_t prot_o,
	output orc_ctl_t ctl_o,
	output logic motor_o
);
	logic motor;
	// Pin level, optionally inverted by software
	assign motor = load_profile_pin_i ^ retry_i[B_INV];
	assign motor_o = motor;
	always_comb begin
		prot_o = '0;
		prot_o.upper_threshold_sel = ocr_i[B_OCH];
		prot_o.middle_threshold_sel = motor ? 1'b0 : ocr_i[B_OCM];
		prot_o.mid_stage_en = !motor;
		prot_o.sense_ratio_sel = ocr_i[B_RATIO];
		if (!ocr_i[B_RANGE]) begin
			prot_o.low_level = orc_low1;
		end else if (ocr_i[B_OCL]) begin
			prot_o.low_level = orc_low3;
		end else begin
			prot_o.low_level = orc_low2;
		end
		if (motor) begin
			// Single window picked by both bits
			unique case ({ocr_i[B_TOCH], ocr_i[B_TOCM]})
				2'b00: prot_o.first_window = orc_win_mid1_m;
				2'b01: prot_o.first_window = orc_win_mid2_m;
				2'b10: prot_o.first_window = orc_win_high1;
				2'b11: prot_o.first_window = orc_win_high2;
			endcase
			prot_o.second_window = orc_win_mid1_l;
			prot_o.second_window_en = 1'b0;
		end else begin
			prot_o.first_window = ocr_i[B_TOCH] ? orc_win_high2 : orc_win_high1;
			prot_o.second_window = ocr_i[B_TOCM] ? orc_win_mid2_l : orc_win_mid1_l;
			prot_o.second_window_en = 1'b1;
		end
		ctl_o.retry_en = motor ? retry_i[B_RETRY] : !retry_i[B_RETRY];
		ctl_o.unlimited = retry_i[B_UNLIM];
		ctl_o.period = {retry_i[B_PER_HI], retry_i[B_PER_LO]};
		ctl_o.sense_offset_polarity = retry_i[B_OFP];
		ctl_o.ext_clock_divider_sel = ocr_i[B_DIV];
		ctl_o.clock_int_sel = ocr_i[B_CLKINT];
	end
endmodule

//--- sim/orc_mcu_model.sv
`timescale 1ns/1ns
// Controller side: hands over one whole configuration word per call
module orc_mcu_model (
	input wire logic ref_clk_i,
	output logic word_valid_o,
	output logic [15:0] spi_word_o
);
	initial begin
		word_valid_o = 1'b0;
		spi_word_o = 16'h0000;
	end
	// Strobe for one cycle; word scrambled after so stale data never helps
	task automatic send(input logic bank, input logic [2:0] addr, input logic [8:0] d, input logic vld);
		@(negedge ref_clk_i);
		spi_word_o = {2'h0, bank, addr, 1'b0, d};
		word_valid_o = vld;
		@(negedge ref_clk_i);
		word_valid_o = 1'b0;
		spi_word_o = ~spi_word_o;
	endtask
endmodule

//--- sim/orc_top_tb_top.sv
`timescale 1ns/1ns
module orc_top_tb_top;
	import orc_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic vld;
	logic [15:0] word;
	logic [1:0] pin, ext_clk, int_tick, on, win, att, crst;
	logic [17:0] ocr_rb, ret_rb;
	orc_prot_t [1:0] prot;
	orc_ctl_t [1:0] ctl;
	logic [1:0] motor, tick, sense_en, allowed, full;
	logic [8:0] ocr [2] = '{9'h000, 9'h000};
	int bad_count = 0;
	int comparisons = 0;
	int n;
	int n2;
	always #5 ref_clk_i = ~ref_clk_i;
	// External PWM clock, four reference cycles per period
	initial ext_clk = 2'h0;
	always #20 ext_clk = ~ext_clk;
	orc_mcu_model u_orc_mcu_model (.ref_clk_i(ref_clk_i), .word_valid_o(vld), .spi_word_o(word));
	orc_top u_orc_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .word_valid_i(vld), .spi_word_i(word),
		.load_profile_pin_i(pin), .ext_clk_i(ext_clk), .int_clk_tick_i(int_tick), .turn_on_i(on),
		.window_active_i(win), .retry_attempt_i(att), .retry_counter_reset_i(crst),
		.ocr_readback_o(ocr_rb), .retry_readback_o(ret_rb), .prot_o(prot), .ctl_o(ctl),
		.motor_profile_o(motor), .pwm_tick_o(tick), .sense_enable_o(sense_en),
		.retry_allowed_o(allowed), .retry_full_o(full));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wclk(input int c);
		repeat (c) @(negedge ref_clk_i);
	endtask
	// Counts PWM ticks of channel 0 over a fixed span
	task automatic cnt(input int c, output int k);
		k = 0;
		repeat (c) begin
			@(posedge ref_clk_i);
			#1 k += int'(tick[0] === 1'b1);
		end
	endtask
	// Bounded wait for the next tick, cycles counted
	task automatic gap(output int k);
		k = 0;
		do begin
			@(posedge ref_clk_i);
			#1 k++;
			if (k > 3000) begin
				bad_count++;
				finish_test();
			end
		end while (tick[0] !== 1'b1);
	endtask
	task automatic t_ocr();
		logic [8:0] d;
		logic m;
		for (int k = 0; k < 32; k++) begin
			d = {k[3], k[1], k[3], k[2], k[1:0], k[0], ~k[1], k[2]};
			m = k[4];
			pin = {m, m};
			u_orc_mcu_model.send(k[0], ADDR_OCR, d, 1'b1);
			ocr[k[0]] = d;
			wclk(2);
			chk("ocr_rb", ocr_rb, {ocr[1], ocr[0]});
			chk("upper", prot[k[0]].upper_threshold_sel, d[2]);
			chk("middle", prot[k[0]].middle_threshold_sel, m ? 1'b0 : d[1]);
			chk("mid_stage", prot[k[0]].mid_stage_en, !m);
			chk("low", prot[k[0]].low_level, !d[8] ? orc_low1 : d[0] ? orc_low3 : orc_low2);
			chk("ratio", prot[k[0]].sense_ratio_sel, d[5]);
			chk("div", ctl[k[0]].ext_clock_divider_sel, d[7]);
			chk("clk_int", ctl[k[0]].clock_int_sel, d[6]);
			if (m) begin
				chk("win_m", prot[k[0]].first_window, d[4] ? (d[3] ? orc_win_high2 : orc_win_high1)
					: (d[3] ? orc_win_mid2_m : orc_win_mid1_m));
				chk("win2_en", prot[k[0]].second_window_en, 1'b0);
			end else begin
				chk("win1", prot[k[0]].first_window, d[4] ? orc_win_high2 : orc_win_high1);
				chk("win2", prot[k[0]].second_window, d[3] ? orc_win_mid2_l : orc_win_mid1_l);
				chk("win2_on", prot[k[0]].second_window_en, 1'b1);
			end
		end
		// Strobe low, then an unmapped address: nothing may move
		u_orc_mcu_model.send(1'b1, ADDR_OCR, 9'h0aa, 1'b0);
		u_orc_mcu_model.send(1'b0, 3'h3, 9'h155, 1'b1);
		wclk(2);
		chk("refused", ocr_rb, {ocr[1], ocr[0]});
	endtask
	task automatic t_retry();
		logic [8:0] d;
		logic m;
		for (int k = 0; k < 32; k++) begin
			d = {k[3], 3'h0, k[2], k[1:0], k[0], k[1] ^ k[3]};
			pin = {k[4], k[4]};
			m = k[4] ^ d[4];
			u_orc_mcu_model.send(k[0], ADDR_RETRY, d, 1'b1);
			wclk(2);
			chk("ret_rb", ret_rb[k[0] * 9 +: 9], d);
			chk("motor", motor[k[0]], m);
			chk("retry_en", ctl[k[0]].retry_en, m ? d[0] : !d[0]);
			chk("unlim", ctl[k[0]].unlimited, d[1]);
			chk("period", ctl[k[0]].period, d[3:2]);
			chk("offset", ctl[k[0]].sense_offset_polarity, d[8]);
		end
	endtask
	task automatic pulse_att(input int c);
		repeat (c) begin
			att[0] = 1'b1;
			wclk(1);
			att[0] = 1'b0;
			wclk(1);
		end
	endtask
	task automatic t_count();
		pin = 2'h0;
		u_orc_mcu_model.send(1'b0, ADDR_RETRY, 9'h000, 1'b1);
		wclk(2);
		pulse_att(15);
		chk("full15", full[0], 1'b0);
		chk("allow15", allowed[0], 1'b1);
		pulse_att(1);
		wclk(1);
		chk("full16", full[0], 1'b1);
		chk("allow16", allowed[0], 1'b0);
		// Fault gone and window toggled: the count must survive
		win[0] = 1'b1;
		wclk(3);
		win[0] = 1'b0;
		wclk(3);
		chk("kept", full[0], 1'b1);
		u_orc_mcu_model.send(1'b0, ADDR_RETRY, 9'h002, 1'b1);
		wclk(2);
		chk("unlim_ok", allowed[0], 1'b1);
		crst[0] = 1'b1;
		wclk(1);
		crst[0] = 1'b0;
		wclk(2);
		chk("cleared", full[0], 1'b0);
	endtask
	task automatic t_sense();
		win[0] = 1'b1;
		wclk(2);
		chk("blank_w", sense_en, 2'h2);
		win[0] = 1'b0;
		on[1] = 1'b1;
		wclk(2);
		chk("blank_on", sense_en, 2'h1);
		on[1] = 1'b0;
		wclk(2);
		chk("sense_on", sense_en, 2'h3);
	endtask
	task automatic t_pwm();
		u_orc_mcu_model.send(1'b0, ADDR_OCR, 9'h000, 1'b1);
		gap(n);
		gap(n);
		chk("div256", n, 32'h400);
		u_orc_mcu_model.send(1'b0, ADDR_OCR, 9'h080, 1'b1);
		gap(n);
		gap(n);
		chk("div512", n, 32'h800);
		// Internal source: external edges must be ignored
		u_orc_mcu_model.send(1'b0, ADDR_OCR, 9'h040, 1'b1);
		wclk(3);
		cnt(2100, n);
		chk("no_ext", n, 0);
		// Tick shows one cycle after the pulse, so counting starts at once
		int_tick[0] = 1'b1;
		cnt(1, n);
		@(negedge ref_clk_i);
		int_tick[0] = 1'b0;
		cnt(4, n2);
		chk("int_tick", n + n2, 1);
	endtask
	initial begin
		{pin, int_tick, on, win, att, crst} = 12'h000;
		repeat (12) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_i = 1'b0;
		chk("rst_ocr", ocr_rb, 18'h0);
		chk("rst_ret", ret_rb, 18'h0);
		t_ocr();
		t_retry();
		t_count();
		t_sense();
		t_pwm();
		finish_test();
	end
endmodule
